//--- common/mmd_pkg.sv
// Address map constants and target enumeration for the memory map decoder
package mmd_pkg;

  localparam int unsigned ADDR_W     = 24;
  localparam int unsigned SEG_W      = 8;
  localparam int unsigned PAGE_W     = 2;
  localparam int unsigned OFS_W      = 14;
  localparam int unsigned SEG_LSB    = 16;
  localparam int unsigned PAGE_LSB   = 14;

  // Region boundaries, inclusive
  localparam logic [23:0] FLASH_IF_LO  = 24'hffff00;
  localparam logic [23:0] FLASH_IF_HI  = 24'hffffff;
  localparam logic [23:0] TRAP_HI_LO   = 24'hf00000;
  localparam logic [23:0] TRAP_HI_HI   = 24'hfffeff;
  localparam logic [23:0] EPRAM_M_LO   = 24'he88000;
  localparam logic [23:0] EPRAM_M_HI   = 24'hefffff;
  localparam logic [23:0] EPRAM_LO     = 24'he80000;
  localparam logic [23:0] EPRAM_HI     = 24'he87fff;
  localparam logic [23:0] PRAM_M_LO    = 24'he08000;
  localparam logic [23:0] PRAM_M_HI    = 24'he7ffff;
  localparam logic [23:0] PRAM_LO      = 24'he00000;
  localparam logic [23:0] PRAM_HI      = 24'he07fff;
  localparam logic [23:0] FLASH_RS_LO  = 24'hcd0000;
  localparam logic [23:0] FLASH_RS_HI  = 24'hdfffff;
  localparam logic [23:0] FLASH_LO     = 24'hc00000;
  localparam logic [23:0] FLASH_HI     = 24'hccffff;
  localparam logic [23:0] FLASH_INT_LO = 24'hc0f000;
  localparam logic [23:0] FLASH_INT_HI = 24'hc0ffff;
  localparam logic [23:0] EXT_HI_LO    = 24'h400000;
  localparam logic [23:0] EXT_HI_HI    = 24'hbfffff;
  localparam logic [23:0] EXT_IO_LO    = 24'h210000;
  localparam logic [23:0] EXT_IO_HI    = 24'h3fffff;
  localparam logic [23:0] RSV_C_LO     = 24'h20c000;
  localparam logic [23:0] RSV_C_HI     = 24'h20ffff;
  localparam logic [23:0] ALT_LO       = 24'h208000;
  localparam logic [23:0] ALT_HI       = 24'h20bfff;
  localparam logic [23:0] RSV_6_LO     = 24'h206000;
  localparam logic [23:0] RSV_6_HI     = 24'h207fff;
  localparam logic [23:0] SER_LO       = 24'h204000;
  localparam logic [23:0] SER_HI       = 24'h205fff;
  localparam logic [23:0] CAN_LO       = 24'h200000;
  localparam logic [23:0] CAN_HI       = 24'h203fff;
  localparam logic [23:0] EXT_MID_LO   = 24'h010000;
  localparam logic [23:0] EXT_MID_HI   = 24'h1fffff;
  localparam logic [23:0] SREG_LO      = 24'h00fe00;
  localparam logic [23:0] SREG_HI      = 24'h00ffff;
  localparam logic [23:0] DPR_LO       = 24'h00f600;
  localparam logic [23:0] DPR_HI       = 24'h00fdff;
  localparam logic [23:0] DPR_RS_LO    = 24'h00f200;
  localparam logic [23:0] DPR_RS_HI    = 24'h00f5ff;
  localparam logic [23:0] EREG_LO      = 24'h00f000;
  localparam logic [23:0] EREG_HI      = 24'h00f1ff;
  localparam logic [23:0] XREG_LO      = 24'h00e000;
  localparam logic [23:0] XREG_HI      = 24'h00efff;
  localparam logic [23:0] DRAM_LO      = 24'h00a000;
  localparam logic [23:0] DRAM_HI      = 24'h00dfff;
  localparam logic [23:0] DRAM_RS_LO   = 24'h008000;
  localparam logic [23:0] DRAM_RS_HI   = 24'h009fff;
  localparam logic [23:0] EXT_LO_LO    = 24'h000000;
  localparam logic [23:0] EXT_LO_HI    = 24'h007fff;

  // Bit addressable windows
  localparam logic [23:0] DPR_BIT_LO   = 24'h00fd00;
  localparam logic [23:0] SREG_BIT_LO  = 24'h00ff00;
  localparam logic [23:0] EREG_BIT_LO  = 24'h00f100;

  // Mirror folding masks, 32 Kbyte images
  localparam logic [23:0] RAM_MIR_MASK = 24'hff8000;
  localparam logic [23:0] RAM_OFS_MASK = 24'h007fff;
  // Alternate window folds onto the CAN block only
  localparam logic [23:0] ALT_TO_BASE  = 24'h008000;

  localparam int unsigned GPR_COUNT    = 16;
  localparam logic [3:0]  PROT_RST     = 4'h0;

  typedef enum logic [3:0] {
    MMD_TGT_NONE,
    MMD_TGT_FLASH_IF,
    MMD_TGT_FLASH,
    MMD_TGT_PRAM,
    MMD_TGT_EPRAM,
    MMD_TGT_EXT_MEM,
    MMD_TGT_EXT_IO,
    MMD_TGT_CAN,
    MMD_TGT_SER,
    MMD_TGT_SREG,
    MMD_TGT_EREG,
    MMD_TGT_XREG,
    MMD_TGT_DUAL_PORT_RAM,
    MMD_TGT_DRAM,
    MMD_TGT_TRAP
  } mmd_tgt_t;

  typedef enum logic [1:0] {
    MMD_UNIT_PROG,
    MMD_UNIT_DATA,
    MMD_UNIT_SYS
  } mmd_unit_t;

endpackage

//--- hw/mmd_decoder.sv
`timescale 1ns/1ps
// Registered address decoder and router for the 16 Mbyte linear space
module mmd_decoder
  import mmd_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        fetch_req_in,
  input  wire logic [23:0] fetch_addr_in,
  input  wire logic        data_req_in,
  input  wire logic        data_we_in,
  input  wire logic        data_byte_in,
  input  wire logic        data_bit_in,
  input  wire logic        data_gpr_in,
  input  wire logic [23:0] data_addr_in,
  input  wire logic [3:0]  prot_size_in,
  input  wire logic [3:0]  gpr_num_in,
  input  wire logic        gpr_high_in,
  input  wire logic [23:0] gpr_base_in,
  output mmd_tgt_t         fetch_tgt_out,
  output logic [23:0]      fetch_addr_out,
  output logic             fetch_valid_out,
  output logic             fetch_trap_out,
  output mmd_tgt_t         data_tgt_out,
  output mmd_unit_t        data_unit_out,
  output logic [23:0]      data_addr_out,
  output logic             data_valid_out,
  output logic             data_we_out,
  output logic [1:0]       data_be_out,
  output logic             data_trap_out,
  output logic             data_noopt_out,
  output logic             sysbus_p2d_out,
  output logic             sysbus_d2p_out,
  output logic [7:0]       seg_out,
  output logic [1:0]       page_out
);

  typedef struct packed {
    mmd_tgt_t    tgt;
    logic [23:0] addr;
    logic        trap;
  } mmd_dec_t;

  logic [23:0] gpr_addr;
  logic [23:0] d_addr;

  // General register address: base plus word index, high byte adds one
  always_comb begin
    gpr_addr = gpr_base_in + {19'h00000, gpr_num_in, 1'b0}
               + {23'h000000, gpr_high_in};
  end

  assign d_addr = data_gpr_in ? gpr_addr : data_addr_in;

  // One comparator per window for the data port; fetch reuses the function
  localparam int NREG = 25;
  localparam logic [23:0] LOS [NREG] = '{
    FLASH_IF_LO, TRAP_HI_LO, EPRAM_M_LO, EPRAM_LO, PRAM_M_LO, PRAM_LO,
    FLASH_RS_LO, FLASH_LO, EXT_HI_LO, EXT_IO_LO, RSV_C_LO, ALT_LO,
    RSV_6_LO, SER_LO, CAN_LO, EXT_MID_LO, SREG_LO, DPR_LO, DPR_RS_LO,
    EREG_LO, XREG_LO, DRAM_LO, DRAM_RS_LO, EXT_LO_LO, FLASH_INT_LO};
  localparam logic [23:0] HIS [NREG] = '{
    FLASH_IF_HI, TRAP_HI_HI, EPRAM_M_HI, EPRAM_HI, PRAM_M_HI, PRAM_HI,
    FLASH_RS_HI, FLASH_HI, EXT_HI_HI, EXT_IO_HI, RSV_C_HI, ALT_HI,
    RSV_6_HI, SER_HI, CAN_HI, EXT_MID_HI, SREG_HI, DPR_HI, DPR_RS_HI,
    EREG_HI, XREG_HI, DRAM_HI, DRAM_RS_HI, EXT_LO_HI, FLASH_INT_HI};

  logic [NREG-1:0] dh;
  logic [NREG-1:0] fh;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_win
      mmd_region #(.LO(LOS[gi]), .HI(HIS[gi])) u_d (
        .addr_in (d_addr),
        .hit_out (dh[gi])
      );
      mmd_region #(.LO(LOS[gi]), .HI(HIS[gi])) u_f (
        .addr_in (fetch_addr_in),
        .hit_out (fh[gi])
      );
    end
  endgenerate

  // Window hits to a single target by priority; the internal flash sector window overlaps flash
  function automatic mmd_dec_t map_hits(input logic [NREG-1:0] h,
                                        input logic [23:0] a);
    mmd_dec_t r;
    r.tgt  = MMD_TGT_TRAP;
    r.addr = a;
    r.trap = 1'b0;
    if (h[0]) r.tgt = MMD_TGT_FLASH_IF;
    else if (h[1] || h[6] || h[10] || h[12] || h[18] || h[22])
      r.trap = 1'b1;
    else if (h[2]) begin
      r.tgt  = MMD_TGT_EPRAM;
      r.addr = EPRAM_LO | (a & RAM_OFS_MASK);
    end else if (h[3]) r.tgt = MMD_TGT_EPRAM;
    else if (h[4]) begin
      r.tgt  = MMD_TGT_PRAM;
      r.addr = PRAM_LO | (a & RAM_OFS_MASK);
    end else if (h[5]) r.tgt = MMD_TGT_PRAM;
    else if (h[7]) r.tgt = MMD_TGT_FLASH;
    else if (h[8] || h[15] || h[23]) r.tgt = MMD_TGT_EXT_MEM;
    else if (h[9]) r.tgt = MMD_TGT_EXT_IO;
    else if (h[11]) begin
      r.addr = a - ALT_TO_BASE;
      r.tgt  = (r.addr >= SER_LO) ? MMD_TGT_SER : MMD_TGT_CAN;
      if (r.addr > SER_HI) r.trap = 1'b1;
    end else if (h[13]) r.tgt = MMD_TGT_SER;
    else if (h[14]) r.tgt = MMD_TGT_CAN;
    else if (h[16]) r.tgt = MMD_TGT_SREG;
    else if (h[17]) r.tgt = MMD_TGT_DUAL_PORT_RAM;
    else if (h[19]) r.tgt = MMD_TGT_EREG;
    else if (h[20]) r.tgt = MMD_TGT_XREG;
    else if (h[21]) r.tgt = MMD_TGT_DRAM;
    if (r.trap) r.tgt = MMD_TGT_TRAP;
    return r;
  endfunction

  // Bit addressing: upper dual-port RAM, register bit windows, any general register in dual-port RAM
  function automatic logic bit_ok(input mmd_tgt_t t, input logic [23:0] a,
                                  input logic general_register);
    logic r;
    r = 1'b0;
    if (t == MMD_TGT_DUAL_PORT_RAM) r = general_register || (a >= DPR_BIT_LO);
    else if (t == MMD_TGT_SREG) r = (a >= SREG_BIT_LO);
    else if (t == MMD_TGT_EREG) r = (a >= EREG_BIT_LO);
    return r;
  endfunction

  mmd_dec_t    fdec;
  mmd_dec_t    ddec;
  logic [23:0] prot_top;
  logic        f_trap;
  logic        d_trap;
  logic        d_prog;
  mmd_unit_t   d_unit;

  // Protected span grows in 2 Kbyte steps from the base of program RAM
  assign prot_top = PRAM_LO + {8'h00, 1'b0, prot_size_in, 11'h000};

  always_comb begin
    fdec = map_hits(fh, fetch_addr_in);
    ddec = map_hits(dh, d_addr);
    // Fetches only come from code stores; internal flash sector is not code
    f_trap = fdec.trap
             || !(fdec.tgt inside {MMD_TGT_FLASH, MMD_TGT_PRAM,
                                   MMD_TGT_EPRAM, MMD_TGT_EXT_MEM})
             || fh[24];
    d_trap = ddec.trap
             || (data_we_in && ddec.tgt == MMD_TGT_PRAM
                 && ddec.addr < prot_top)
             || (data_bit_in && !bit_ok(ddec.tgt, ddec.addr, data_gpr_in))
             || (data_we_in && ddec.tgt inside {MMD_TGT_FLASH,
                                                 MMD_TGT_FLASH_IF})
             || (!data_byte_in && ddec.addr[0]);
    // Program-side stores reach the data side over the system bus
    d_prog = ddec.tgt inside {MMD_TGT_FLASH, MMD_TGT_PRAM, MMD_TGT_EPRAM,
                              MMD_TGT_FLASH_IF};
    if (d_prog) d_unit = MMD_UNIT_PROG;
    else if (ddec.tgt inside {MMD_TGT_EXT_MEM, MMD_TGT_EXT_IO,
                              MMD_TGT_CAN, MMD_TGT_SER})
      d_unit = MMD_UNIT_SYS;
    else d_unit = MMD_UNIT_DATA;
  end

  // Fetch side registers
  mmd_tgt_t    f_tgt_d,   f_tgt_q;
  logic [23:0] f_addr_d,  f_addr_q;
  logic        f_vld_d,   f_vld_q;
  logic        f_trp_d,   f_trp_q;

  always_comb begin
    f_vld_d  = fetch_req_in && !f_trap;
    f_trp_d  = fetch_req_in && f_trap;
    f_tgt_d  = fetch_req_in ? (f_trap ? MMD_TGT_TRAP : fdec.tgt)
                            : MMD_TGT_NONE;
    f_addr_d = fdec.addr;
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      f_tgt_q  <= MMD_TGT_NONE;
      f_addr_q <= 24'h000000;
      f_vld_q  <= 1'b0;
      f_trp_q  <= 1'b0;
    end else begin
      f_tgt_q  <= f_tgt_d;
      f_addr_q <= f_addr_d;
      f_vld_q  <= f_vld_d;
      f_trp_q  <= f_trp_d;
    end
  end

  // Data side registers
  mmd_tgt_t    d_tgt_d,   d_tgt_q;
  mmd_unit_t   d_unit_d,  d_unit_q;
  logic [23:0] d_addr_d,  d_addr_q;
  logic        d_vld_d,   d_vld_q;
  logic        d_we_d,    d_we_q;
  logic [1:0]  d_be_d,    d_be_q;
  logic        d_trp_d,   d_trp_q;
  logic        d_nop_d,   d_nop_q;
  logic        p2d_d,     p2d_q;
  logic        d2p_d,     d2p_q;
  logic [7:0]  seg_d,     seg_q;
  logic [1:0]  pg_d,      pg_q;

  always_comb begin
    d_vld_d  = data_req_in && !d_trap;
    d_trp_d  = data_req_in && d_trap;
    d_tgt_d  = data_req_in ? (d_trap ? MMD_TGT_TRAP : ddec.tgt)
                           : MMD_TGT_NONE;
    d_unit_d = d_unit;
    d_addr_d = ddec.addr;
    d_we_d   = data_req_in && data_we_in && !d_trap;
    // Byte lane from address bit 0, word uses both lanes
    d_be_d   = !data_req_in ? 2'h0 : data_byte_in
               ? (ddec.addr[0] ? 2'h2 : 2'h1) : 2'h3;
    d_nop_d  = d_vld_d && ddec.tgt == MMD_TGT_EXT_IO;
    // Both directions may be busy in the same cycle
    p2d_d    = d_vld_d && d_prog && !data_we_in;
    d2p_d    = (d_vld_d && d_prog && data_we_in)
               || (f_vld_d && fdec.tgt == MMD_TGT_EXT_MEM);
    seg_d    = d_addr[SEG_LSB +: SEG_W];
    pg_d     = d_addr[PAGE_LSB +: PAGE_W];
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      d_tgt_q  <= MMD_TGT_NONE;
      d_unit_q <= MMD_UNIT_DATA;
      d_addr_q <= 24'h000000;
      d_vld_q  <= 1'b0;
      d_we_q   <= 1'b0;
      d_be_q   <= 2'h0;
      d_trp_q  <= 1'b0;
      d_nop_q  <= 1'b0;
      p2d_q    <= 1'b0;
      d2p_q    <= 1'b0;
      seg_q    <= 8'h00;
      pg_q     <= 2'h0;
    end else begin
      d_tgt_q  <= d_tgt_d;
      d_unit_q <= d_unit_d;
      d_addr_q <= d_addr_d;
      d_vld_q  <= d_vld_d;
      d_we_q   <= d_we_d;
      d_be_q   <= d_be_d;
      d_trp_q  <= d_trp_d;
      d_nop_q  <= d_nop_d;
      p2d_q    <= p2d_d;
      d2p_q    <= d2p_d;
      seg_q    <= seg_d;
      pg_q     <= pg_d;
    end
  end

  assign fetch_tgt_out   = f_tgt_q;
  assign fetch_addr_out  = f_addr_q;
  assign fetch_valid_out = f_vld_q;
  assign fetch_trap_out  = f_trp_q;
  assign data_tgt_out    = d_tgt_q;
  assign data_unit_out   = d_unit_q;
  assign data_addr_out   = d_addr_q;
  assign data_valid_out  = d_vld_q;
  assign data_we_out     = d_we_q;
  assign data_be_out     = d_be_q;
  assign data_trap_out   = d_trp_q;
  assign data_noopt_out  = d_nop_q;
  assign sysbus_p2d_out  = p2d_q;
  assign sysbus_d2p_out  = d2p_q;
  assign seg_out         = seg_q;
  assign page_out        = pg_q;

  // Checks
  sequence s_pram_wr_prot;
    data_req_in && data_we_in && d_addr >= PRAM_LO && d_addr < prot_top;
  endsequence

  prot_block_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_pram_wr_prot |=> data_trap_out && !data_we_out)
    else $error("protected program RAM write not blocked");
  flash_int_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    fetch_req_in && fetch_addr_in >= FLASH_INT_LO
      && fetch_addr_in <= FLASH_INT_HI |=> fetch_trap_out)
    else $error("fetch from internal flash sector allowed");
  ext_io_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    data_noopt_out |-> data_tgt_out == MMD_TGT_EXT_IO
      && data_addr_out >= EXT_IO_LO && data_addr_out <= EXT_IO_HI)
    else $error("no-optimise flag outside external io area");
  // Fold lands the whole alternate page on the CAN block; odd words trap
  alt_win_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    data_req_in && !data_we_in && !data_bit_in && !data_gpr_in
      && (data_byte_in || !data_addr_in[0])
      && data_addr_in >= ALT_LO && data_addr_in <= ALT_HI
      |=> data_tgt_out == MMD_TGT_CAN
      && data_addr_out == $past(data_addr_in) - ALT_TO_BASE)
    else $error("alternate window not folded");
  seg_zero_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    data_valid_out && data_tgt_out inside {MMD_TGT_DRAM, MMD_TGT_DUAL_PORT_RAM,
      MMD_TGT_SREG, MMD_TGT_EREG, MMD_TGT_XREG} |-> seg_out == 8'h00)
    else $error("internal target outside segment 0");
  mirror_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    data_valid_out && data_tgt_out == MMD_TGT_PRAM
      |-> data_addr_out <= PRAM_HI)
    else $error("program RAM mirror not folded");
  byte_lane_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    data_valid_out |-> (data_be_out == 2'h3) == !$past(data_byte_in)
      && (data_be_out != 2'h3 || !data_addr_out[0]))
    else $error("byte lanes wrong");
  gpr_bit_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    data_req_in && data_bit_in && data_gpr_in && !data_we_in
      && data_byte_in && d_addr >= DPR_LO && d_addr <= DPR_HI
      |=> data_valid_out && !data_trap_out)
    else $error("register bit access refused");
  fetch_unit_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    fetch_valid_out |-> fetch_tgt_out inside {MMD_TGT_FLASH, MMD_TGT_PRAM,
      MMD_TGT_EPRAM, MMD_TGT_EXT_MEM})
    else $error("fetch routed to non-code target");

endmodule // mmd_decoder

//--- hw/mmd_region.sv
`timescale 1ns/1ps
// Single address window comparator, inclusive bounds
module mmd_region #(
  parameter logic [23:0] LO = 24'h000000,
  parameter logic [23:0] HI = 24'h000000
) (
  input  wire logic [23:0] addr_in,
  output logic             hit_out
);
  assign hit_out = (addr_in >= LO) && (addr_in <= HI);
endmodule // mmd_region

//--- test/mmd_cpu_model.sv
`timescale 1ns/1ps
// Behavioural CPU core that issues fetch and data requests to the decoder
module mmd_cpu_model (
  input  wire logic  core_clk_in,
  output logic       fetch_req_out,
  output logic [23:0] fetch_addr_out,
  output logic       data_req_out,
  output logic       data_we_out,
  output logic       data_byte_out,
  output logic       data_bit_out,
  output logic       data_gpr_out,
  output logic [23:0] data_addr_out,
  output logic [3:0] prot_size_out,
  output logic [3:0] gpr_num_out,
  output logic       gpr_high_out,
  output logic [23:0] gpr_base_out
);
  initial begin
    fetch_req_out  = 1'b0;
    fetch_addr_out = 24'h000000;
    data_req_out   = 1'b0;
    data_addr_out  = 24'h000000;
    {data_we_out, data_byte_out, data_bit_out, data_gpr_out} = 4'h0;
    prot_size_out  = 4'h0;
    gpr_num_out    = 4'h0;
    gpr_high_out   = 1'b0;
    gpr_base_out   = 24'h000000;
  end
  // Level inputs, changed only at a falling edge by the caller
  task automatic setup(input logic [3:0] prot, input logic [23:0] base,
                       input logic [3:0] num, input logic high);
    prot_size_out = prot;
    gpr_base_out  = base;
    gpr_num_out   = num;
    gpr_high_out  = high;
  endtask
  // Held over exactly one taking edge; calls may follow back to back
  task automatic issue(input logic f_en, input logic [23:0] f_a,
                       input logic d_en, input logic [23:0] d_a,
                       input logic [3:0] mode);
    fetch_req_out  = f_en;
    fetch_addr_out = f_a;
    data_req_out   = d_en;
    data_addr_out  = d_a;
    {data_we_out, data_byte_out, data_bit_out, data_gpr_out} = mode;
    @(negedge core_clk_in);
  endtask
  // Released lines flip so a stale address can never look valid
  task automatic idle();
    fetch_req_out  = 1'b0;
    data_req_out   = 1'b0;
    fetch_addr_out = ~fetch_addr_out;
    data_addr_out  = ~data_addr_out;
    @(negedge core_clk_in);
  endtask
endmodule // mmd_cpu_model

//--- test/test_memory_map_decoder.sv
`timescale 1ns/1ps
// Self-checking testbench for the memory map decoder
module test_memory_map_decoder
  import mmd_pkg::*;
;
  localparam logic [3:0] RD = 4'h0;
  localparam logic [3:0] BY = 4'h4;
  localparam logic [3:0] BT = 4'h2;
  localparam logic [3:0] GP = 4'h1;
  localparam logic [3:0] WR = 4'h8;
  logic core_clk_in = 1'b0;
  logic reset_in    = 1'b1;
  logic fetch_req_in, data_req_in, data_we_in, data_byte_in;
  logic data_bit_in, data_gpr_in, gpr_high_in;
  logic [23:0] fetch_addr_in, data_addr_in, gpr_base_in;
  logic [3:0] prot_size_in, gpr_num_in;
  mmd_tgt_t fetch_tgt_out, data_tgt_out;
  mmd_unit_t data_unit_out;
  logic [23:0] fetch_addr_out, data_addr_out;
  logic fetch_valid_out, fetch_trap_out, data_valid_out, data_we_out;
  logic data_trap_out, data_noopt_out, sysbus_p2d_out, sysbus_d2p_out;
  logic [1:0] data_be_out, page_out;
  logic [7:0] seg_out;
  int fail_count = 0;
  int checks = 0;

  always #2 core_clk_in = ~core_clk_in;

  mmd_cpu_model mmd_cpu_model_i (
    .core_clk_in(core_clk_in), .fetch_req_out(fetch_req_in),
    .fetch_addr_out(fetch_addr_in), .data_req_out(data_req_in),
    .data_we_out(data_we_in), .data_byte_out(data_byte_in),
    .data_bit_out(data_bit_in), .data_gpr_out(data_gpr_in),
    .data_addr_out(data_addr_in), .prot_size_out(prot_size_in),
    .gpr_num_out(gpr_num_in), .gpr_high_out(gpr_high_in),
    .gpr_base_out(gpr_base_in));

  mmd_decoder mmd_decoder_i (
    .core_clk_in(core_clk_in), .reset_in(reset_in),
    .fetch_req_in(fetch_req_in), .fetch_addr_in(fetch_addr_in),
    .data_req_in(data_req_in), .data_we_in(data_we_in),
    .data_byte_in(data_byte_in), .data_bit_in(data_bit_in),
    .data_gpr_in(data_gpr_in), .data_addr_in(data_addr_in),
    .prot_size_in(prot_size_in), .gpr_num_in(gpr_num_in),
    .gpr_high_in(gpr_high_in), .gpr_base_in(gpr_base_in),
    .fetch_tgt_out(fetch_tgt_out), .fetch_addr_out(fetch_addr_out),
    .fetch_valid_out(fetch_valid_out), .fetch_trap_out(fetch_trap_out),
    .data_tgt_out(data_tgt_out), .data_unit_out(data_unit_out),
    .data_addr_out(data_addr_out), .data_valid_out(data_valid_out),
    .data_we_out(data_we_out), .data_be_out(data_be_out),
    .data_trap_out(data_trap_out), .data_noopt_out(data_noopt_out),
    .sysbus_p2d_out(sysbus_p2d_out), .sysbus_d2p_out(sysbus_d2p_out),
    .seg_out(seg_out), .page_out(page_out));

  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One data request; a trap must come alone, without valid
  task automatic dchk(input logic [23:0] a, input logic [3:0] m,
                      input mmd_tgt_t t, input logic [23:0] f);
    mmd_cpu_model_i.issue(1'b0, 24'h000000, 1'b1, a, m);
    chk("data_tgt", 24'(t), 24'(data_tgt_out));
    chk("data_trap", 24'(t == MMD_TGT_TRAP), 24'(data_trap_out));
    chk("data_valid", 24'(t != MMD_TGT_TRAP), 24'(data_valid_out));
    if (t != MMD_TGT_TRAP) begin
      chk("data_addr", f, data_addr_out);
      chk("data_we", 24'(m[3]), 24'(data_we_out));
    end
  endtask
  task automatic fchk(input logic [23:0] a, input mmd_tgt_t t,
                      input logic [23:0] f);
    mmd_cpu_model_i.issue(1'b1, a, 1'b0, 24'h000000, RD);
    chk("fetch_tgt", 24'(t), 24'(fetch_tgt_out));
    chk("fetch_trap", 24'(t == MMD_TGT_TRAP), 24'(fetch_trap_out));
    chk("fetch_valid", 24'(t != MMD_TGT_TRAP), 24'(fetch_valid_out));
    if (t != MMD_TGT_TRAP) chk("fetch_addr", f, fetch_addr_out);
  endtask

  task automatic t_reset();
    chk("rst_tgt", 24'(MMD_TGT_NONE), 24'(data_tgt_out));
    chk("rst_unit", 24'(MMD_UNIT_DATA), 24'(data_unit_out));
    chk("rst_ftgt", 24'(MMD_TGT_NONE), 24'(fetch_tgt_out));
    chk("rst_pulses", 24'h0, 24'({data_valid_out, data_trap_out,
        fetch_valid_out, fetch_trap_out, sysbus_p2d_out, sysbus_d2p_out,
        data_we_out, data_noopt_out, data_be_out, seg_out, page_out}));
    chk("rst_addr", 24'h0, data_addr_out | fetch_addr_out);
  endtask
  // Byte lanes, odd word refusal and segment/page split, back to back
  task automatic t_access();
    dchk(24'h00a001, BY, MMD_TGT_DRAM, 24'h00a001);
    chk("be", 24'h2, 24'(data_be_out));
    chk("unit", 24'(MMD_UNIT_DATA), 24'(data_unit_out));
    chk("seg", 24'h00, 24'(seg_out));
    chk("page", 24'h2, 24'(page_out));
    dchk(24'h00a001, RD, MMD_TGT_TRAP, 24'h0);
    dchk(24'h00c002, WR, MMD_TGT_DRAM, 24'h00c002);
    chk("be", 24'h3, 24'(data_be_out));
    dchk(24'h3fc000, BY, MMD_TGT_EXT_IO, 24'h3fc000);
    chk("seg", 24'h3f, 24'(seg_out));
    chk("page", 24'h3, 24'(page_out));
    mmd_cpu_model_i.idle();
  endtask
  task automatic t_map();
    dchk(24'h000100, RD, MMD_TGT_EXT_MEM, 24'h000100);
    dchk(24'h008000, RD, MMD_TGT_TRAP, 24'h0);
    dchk(24'h00e000, RD, MMD_TGT_XREG, 24'h00e000);
    dchk(24'h00f000, RD, MMD_TGT_EREG, 24'h00f000);
    dchk(24'h00f200, RD, MMD_TGT_TRAP, 24'h0);
    dchk(24'h00f600, RD, MMD_TGT_DUAL_PORT_RAM, 24'h00f600);
    dchk(24'h00fe00, RD, MMD_TGT_SREG, 24'h00fe00);
    dchk(24'h01a000, RD, MMD_TGT_EXT_MEM, 24'h01a000);
    dchk(24'h200000, RD, MMD_TGT_CAN, 24'h200000);
    dchk(24'h204000, RD, MMD_TGT_SER, 24'h204000);
    dchk(24'h206000, RD, MMD_TGT_TRAP, 24'h0);
    dchk(24'h209000, RD, MMD_TGT_CAN, 24'h201000);
    dchk(24'h20c000, RD, MMD_TGT_TRAP, 24'h0);
    dchk(24'h400000, RD, MMD_TGT_EXT_MEM, 24'h400000);
    dchk(24'hc00000, RD, MMD_TGT_FLASH, 24'hc00000);
    dchk(24'hcd0000, RD, MMD_TGT_TRAP, 24'h0);
    dchk(24'he08010, RD, MMD_TGT_PRAM, 24'he00010);
    dchk(24'he88010, RD, MMD_TGT_EPRAM, 24'he80010);
    dchk(24'hf00000, RD, MMD_TGT_TRAP, 24'h0);
    dchk(24'hffff00, RD, MMD_TGT_FLASH_IF, 24'hffff00);
    mmd_cpu_model_i.idle();
  endtask
  task automatic t_fetch();
    fchk(24'hc00000, MMD_TGT_FLASH, 24'hc00000);
    fchk(24'hc0eff0, MMD_TGT_FLASH, 24'hc0eff0);
    fchk(24'hc0f000, MMD_TGT_TRAP, 24'h0);
    fchk(24'hc0fffe, MMD_TGT_TRAP, 24'h0);
    fchk(24'he08000, MMD_TGT_PRAM, 24'he00000);
    fchk(24'he80000, MMD_TGT_EPRAM, 24'he80000);
    fchk(24'h400000, MMD_TGT_EXT_MEM, 24'h400000);
    fchk(24'h00a000, MMD_TGT_TRAP, 24'h0);
    mmd_cpu_model_i.idle();
  endtask
  // Two 2 Kbyte units protected; reads and the first free word still pass
  task automatic t_prot();
    mmd_cpu_model_i.setup(4'h2, 24'h00f600, 4'hf, 1'b1);
    dchk(24'he00ffe, WR, MMD_TGT_TRAP, 24'h0);
    dchk(24'he01000, WR, MMD_TGT_PRAM, 24'he01000);
    dchk(24'he00000, RD, MMD_TGT_PRAM, 24'he00000);
    dchk(24'he08800, WR, MMD_TGT_TRAP, 24'h0);
    dchk(24'hc00000, WR, MMD_TGT_TRAP, 24'h0);
    mmd_cpu_model_i.idle();
  endtask
  task automatic t_bit();
    dchk(24'h00fd00, BT, MMD_TGT_DUAL_PORT_RAM, 24'h00fd00);
    dchk(24'h00fcfe, BT, MMD_TGT_TRAP, 24'h0);
    dchk(24'h00ff00, BT, MMD_TGT_SREG, 24'h00ff00);
    dchk(24'h00fe00, BT, MMD_TGT_TRAP, 24'h0);
    dchk(24'h00f100, BT, MMD_TGT_EREG, 24'h00f100);
    dchk(24'h00a000, BT, MMD_TGT_TRAP, 24'h0);
    dchk(24'h123456, BY | BT | GP, MMD_TGT_DUAL_PORT_RAM, 24'h00f61f);
    chk("be", 24'h2, 24'(data_be_out));
    mmd_cpu_model_i.setup(4'h2, 24'h00f600, 4'h3, 1'b0);
    dchk(24'h00a001, GP, MMD_TGT_DUAL_PORT_RAM, 24'h00f606);
    chk("be", 24'h3, 24'(data_be_out));
    mmd_cpu_model_i.idle();
  endtask
  // Both system bus directions in the same cycle
  task automatic t_sys();
    mmd_cpu_model_i.issue(1'b1, 24'h400000, 1'b1, 24'hc00000, RD);
    chk("p2d", 24'h1, 24'(sysbus_p2d_out));
    chk("d2p", 24'h1, 24'(sysbus_d2p_out));
    chk("both_valid", 24'h3, 24'({fetch_valid_out, data_valid_out}));
    dchk(24'h00a000, RD, MMD_TGT_DRAM, 24'h00a000);
    chk("p2d_d2p", 24'h0, 24'({sysbus_p2d_out, sysbus_d2p_out}));
    dchk(24'h210000, RD, MMD_TGT_EXT_IO, 24'h210000);
    chk("noopt", 24'h1, 24'(data_noopt_out));
    chk("unit", 24'(MMD_UNIT_SYS), 24'(data_unit_out));
    dchk(24'h400000, RD, MMD_TGT_EXT_MEM, 24'h400000);
    chk("noopt", 24'h0, 24'(data_noopt_out));
    dchk(24'hffff00, RD, MMD_TGT_FLASH_IF, 24'hffff00);
    chk("unit", 24'(MMD_UNIT_PROG), 24'(data_unit_out));
    mmd_cpu_model_i.idle();
  endtask

  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run needs about 60 cycles; 1000 leaves ample margin
  initial begin
    #4000;
    fail_count++;
    results();
  end

  initial begin
    repeat (2) @(negedge core_clk_in);
    t_reset();
    reset_in = 1'b0;
    // First request only after an edge has seen reset low
    @(negedge core_clk_in);
    t_access();
    t_map();
    t_fetch();
    t_prot();
    t_bit();
    t_sys();
    results();
  end
endmodule // test_memory_map_decoder
